// [logic/evp_pkg.sv]
// package of the exception vector priority block: vector offsets, defaults, widths
// assumes nothing of its surroundings; imported by both design modules
package evp_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int          EVP_VEC_W        = 16;
    localparam int          EVP_BYTE_W       = 8;
    // number of device specific I-maskable sources (offsets 0xF0 down to 0x82)
    localparam int          EVP_DEV_SRC_N    = 56;
    // ************************************************************
    // fixed reset vectors
    // ************************************************************
    localparam logic [15:0] EVP_VEC_RST_PIN  = 16'hFFFE;
    localparam logic [15:0] EVP_VEC_RST_CLK  = 16'hFFFC;
    localparam logic [15:0] EVP_VEC_RST_WDOG = 16'hFFFA;
    // ************************************************************
    // offsets from the vector base (low byte)
    // ************************************************************
    localparam logic [7:0]  EVP_OFS_TRAP     = 8'hF8;
    localparam logic [7:0]  EVP_OFS_SOFT     = 8'hF6;
    localparam logic [7:0]  EVP_OFS_XMASK    = 8'hF4;
    localparam logic [7:0]  EVP_OFS_LINK     = 8'hF2;
    localparam logic [7:0]  EVP_OFS_DEV_TOP  = 8'hF0;
    localparam logic [7:0]  EVP_OFS_DEV_BOT  = 8'h82;
    localparam logic [7:0]  EVP_OFS_SPUR     = 8'h80;
    localparam logic [7:0]  EVP_OFS_STEP     = 8'h02;
    // ************************************************************
    // vector base defaults
    // ************************************************************
    localparam logic [7:0]  EVP_BASE_RESET   = 8'hFF;
    localparam logic [7:0]  EVP_BASE_DEBUG   = 8'hFF;
    localparam logic [7:0]  EVP_BASE_LOW     = 8'h00;
endpackage : evp_pkg

// [logic/evp_imask_pick.sv]
// priority picker over the device specific I-maskable sources
// assumes request and enable vectors are synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module evp_imask_pick
    import evp_pkg::*;
#(
    parameter int N = EVP_DEV_SRC_N
) (
    input  wire logic [N-1:0] i_req,
    input  wire logic [N-1:0] i_en,
    output logic              o_hit,
    output logic [7:0]        o_ofs
);
    // index 0 sits at the top offset; lower index wins
    if (N < 1 || N > EVP_DEV_SRC_N) begin : g_bad_n
        $error("evp_imask_pick: N out of range");
    end

    logic [N-1:0] live;
    assign live = i_req & i_en;

    always_comb begin
        o_hit = 1'b0;
        o_ofs = EVP_OFS_SPUR;
        for (int k = N - 1; k >= 0; k--) begin
            if (live[k]) begin
                o_hit = 1'b1;
                o_ofs = 8'(EVP_OFS_DEV_TOP - 8'(k) * EVP_OFS_STEP);
            end
        end
    end
endmodule : evp_imask_pick
`default_nettype wire

// [logic/evp_top.sv]
// exception vector priority decoder: ranks resets, trap, soft interrupt,
// X-maskable and I-maskable requests and supplies the winning 16-bit vector
// assumes the cpu holds i_vec_req until it sees o_vec_valid, then pulses i_vec_ack;
// wake sources other than async ones are gated by the clock controller
// the vector is chosen at the taking edge: a request that drops later still gets
// its vector, one that drops earlier falls back to the spurious vector
`timescale 1ns/1ps
`default_nettype none
module evp_top
    import evp_pkg::*;
#(
    parameter int N_DEV = EVP_DEV_SRC_N
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // cpu side
    input  wire logic             i_vec_req,
    input  wire logic             i_vec_ack,
    input  wire logic             i_ccr_i_bit,
    input  wire logic             i_ccr_x_bit,
    input  wire logic             i_debug_active,
    input  wire logic             i_base_wr,
    input  wire logic [7:0]       i_base_wdata,
    input  wire logic             i_stop_mode,
    input  wire logic             i_wait_mode,
    // reset causes
    input  wire logic             i_rst_pin_req,
    input  wire logic             i_rst_clk_req,
    input  wire logic             i_rst_wdog_req,
    // exception requests
    input  wire logic             i_trap_req,
    input  wire logic             i_soft_req,
    input  wire logic             i_xmask_req,
    input  wire logic             i_link_req,
    input  wire logic             i_link_en,
    input  wire logic [N_DEV-1:0] i_dev_req,
    input  wire logic [N_DEV-1:0] i_dev_en,
    input  wire logic [N_DEV-1:0] i_dev_async,
    // outputs
    output logic [15:0]           o_vec_addr,
    output logic                  o_vec_valid,
    output logic [7:0]            o_base_rdata,
    output logic                  o_wake
);
    // a count beyond the offset range would alias onto the spurious vector
    if (N_DEV < 1 || N_DEV > EVP_DEV_SRC_N) begin : g_bad_count
        $error("evp_top: N_DEV out of range");
    end

    // ************************************************************
    // vector base register
    // ************************************************************
    logic [7:0] vector_base_reg;
    logic [7:0] vector_base_next;

    always_comb begin
        vector_base_next = vector_base_reg;
        if (i_base_wr) begin
            vector_base_next = i_base_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            vector_base_reg <= EVP_BASE_RESET;
        end else begin
            vector_base_reg <= vector_base_next;
        end
    end

    logic [7:0] base_hi;
    // debug firmware must reach all non-maskable handlers at a fixed table
    assign base_hi = i_debug_active ? EVP_BASE_DEBUG : vector_base_reg;

    // ************************************************************
    // device source picker
    // ************************************************************
    logic       dev_hit;
    logic [7:0] dev_ofs;

    evp_imask_pick #(
        .N     (N_DEV)
    ) u_pick (
        .i_req (i_dev_req),
        .i_en  (i_dev_en),
        .o_hit (dev_hit),
        .o_ofs (dev_ofs)
    );

    // ************************************************************
    // qualification
    // ************************************************************
    logic high_pending;
    logic xmask_ok;
    logic imask_ok;
    logic link_ok;
    logic dev_ok;

    always_comb begin
        // X-maskable interrupt is gated by its own mask bit only
        xmask_ok     = i_xmask_req & ~i_ccr_x_bit;
        // a pending X-maskable request holds I-maskables off even while X masks it
        high_pending = i_trap_req | i_soft_req | i_xmask_req;
        // I-mask bit stays set inside a routine until software clears it
        imask_ok     = ~i_ccr_i_bit & ~high_pending;
        // the link source ranks above every device source
        link_ok      = i_link_req & i_link_en & imask_ok;
        dev_ok       = dev_hit & imask_ok;
    end

    // ************************************************************
    // priority decode
    // ************************************************************
    // one class per row of the vector table, one class for all device rows, listed from highest to lowest
    typedef enum logic [3:0] {
        EVP_CLS_RST_PIN,
        EVP_CLS_RST_CLK,
        EVP_CLS_RST_WDOG,
        EVP_CLS_TRAP,
        EVP_CLS_SOFT,
        EVP_CLS_XMASK,
        EVP_CLS_LINK,
        EVP_CLS_DEV,
        EVP_CLS_SPUR
    } evp_class_e;

    evp_class_e  win_cls;
    logic [15:0] win_vec;

    always_comb begin
        // higher address is checked first so it wins
        if (i_rst_pin_req) begin
            win_cls = EVP_CLS_RST_PIN;
        end else if (i_rst_clk_req) begin
            win_cls = EVP_CLS_RST_CLK;
        end else if (i_rst_wdog_req) begin
            win_cls = EVP_CLS_RST_WDOG;
        end else if (i_trap_req) begin
            win_cls = EVP_CLS_TRAP;
        end else if (i_soft_req) begin
            win_cls = EVP_CLS_SOFT;
        end else if (xmask_ok) begin
            win_cls = EVP_CLS_XMASK;
        end else if (link_ok) begin
            win_cls = EVP_CLS_LINK;
        end else if (dev_ok) begin
            win_cls = EVP_CLS_DEV;
        end else begin
            // request vanished before the fetch
            win_cls = EVP_CLS_SPUR;
        end
    end

    // ************************************************************
    // class to vector map
    // ************************************************************
    // reset vectors are absolute so a rewritten base can never move them
    always_comb begin
        case (win_cls)
            EVP_CLS_RST_PIN: begin
                win_vec = EVP_VEC_RST_PIN;
            end
            EVP_CLS_RST_CLK: begin
                win_vec = EVP_VEC_RST_CLK;
            end
            EVP_CLS_RST_WDOG: begin
                win_vec = EVP_VEC_RST_WDOG;
            end
            EVP_CLS_TRAP: begin
                win_vec = {base_hi, EVP_OFS_TRAP};
            end
            EVP_CLS_SOFT: begin
                win_vec = {base_hi, EVP_OFS_SOFT};
            end
            EVP_CLS_XMASK: begin
                win_vec = {base_hi, EVP_OFS_XMASK};
            end
            EVP_CLS_LINK: begin
                win_vec = {base_hi, EVP_OFS_LINK};
            end
            EVP_CLS_DEV: begin
                win_vec = {base_hi, dev_ofs};
            end
            EVP_CLS_SPUR: begin
                win_vec = {base_hi, EVP_OFS_SPUR};
            end
            default: begin
                win_vec = {base_hi, EVP_OFS_SPUR};
            end
        endcase
    end

    // ************************************************************
    // vector handshake
    // ************************************************************
    typedef enum logic [0:0] {
        EVP_IDLE,
        EVP_HOLD
    } evp_state_e;

    evp_state_e  state_reg;
    evp_state_e  state_next;
    logic [15:0] vec_reg;
    logic [15:0] vec_next;
    logic        valid_reg;
    logic        valid_next;

    always_comb begin
        state_next = state_reg;
        vec_next   = vec_reg;
        valid_next = valid_reg;
        case (state_reg)
            EVP_IDLE: begin
                if (i_vec_req) begin
                    vec_next   = win_vec;
                    valid_next = 1'b1;
                    state_next = EVP_HOLD;
                end
            end
            EVP_HOLD: begin
                // vector frozen until taken, later requests cannot disturb it
                if (i_vec_ack) begin
                    valid_next = 1'b0;
                    state_next = EVP_IDLE;
                end
            end
            default: begin
                valid_next = 1'b0;
                state_next = EVP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg <= EVP_IDLE;
            vec_reg   <= EVP_VEC_RST_PIN;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            vec_reg   <= vec_next;
            valid_reg <= valid_next;
        end
    end

    // ************************************************************
    // wake-up
    // ************************************************************
    logic [N_DEV-1:0] dev_wake_src;
    logic             link_wake;
    logic             wake_next;
    logic             wake_reg;

    always_comb begin
        wake_next    = 1'b0;
        // in stop only sources flagged asynchronous may wake; link counts as clocked
        dev_wake_src = i_dev_req & i_dev_en;
        if (i_stop_mode) begin
            dev_wake_src = dev_wake_src & i_dev_async;
        end
        link_wake    = link_ok & ~i_stop_mode;
        // the I bit masks every source from waking, as it does in run mode
        if ((i_stop_mode | i_wait_mode) && !i_ccr_i_bit) begin
            wake_next = link_wake | (|dev_wake_src);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= wake_next;
        end
    end

    // ************************************************************
    // outputs, each straight from a register
    // ************************************************************
    assign o_vec_addr   = vec_reg;
    assign o_vec_valid  = valid_reg;
    assign o_base_rdata = vector_base_reg;
    assign o_wake       = wake_reg;
endmodule : evp_top
`default_nettype wire

// [bench/evp_top_asserts.sv]
// checker of the vector priority block, bound into evp_top
// assumes one clock domain and the synchronous reset of the top
`timescale 1ns/1ps
`default_nettype none
module evp_top_chk
    import evp_pkg::*;
#(
    parameter int N_DEV = EVP_DEV_SRC_N
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_vec_req,
    input wire logic i_vec_ack,
    input wire logic i_ccr_i_bit,
    input wire logic i_debug_active,
    input wire logic i_base_wr,
    input wire logic [7:0] i_base_wdata,
    input wire logic i_stop_mode,
    input wire logic i_rst_pin_req,
    input wire logic i_rst_clk_req,
    input wire logic i_rst_wdog_req,
    input wire logic i_trap_req,
    input wire logic [N_DEV-1:0] i_dev_req,
    input wire logic [N_DEV-1:0] i_dev_en,
    input wire logic [N_DEV-1:0] i_dev_async,
    input wire logic [15:0] o_vec_addr,
    input wire logic o_vec_valid,
    input wire logic [7:0] o_base_rdata,
    input wire logic o_wake
);
    // ********
    // properties
    // ********
    wire logic take = i_vec_req && !o_vec_valid;
    wire logic [7:0] base_c = i_debug_active ? EVP_BASE_DEBUG : o_base_rdata;
    wire logic as_ok = |(i_dev_req & i_dev_en & i_dev_async);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    take_valid_a: assert property (take |=> o_vec_valid) else $error("no valid");
    pin_vec_a: assert property (take && i_rst_pin_req |=> o_vec_addr == EVP_VEC_RST_PIN) else $error("pin");
    clk_vec_a: assert property (take && !i_rst_pin_req && i_rst_clk_req |=> o_vec_addr == EVP_VEC_RST_CLK)
        else $error("clk");
    wdog_vec_a: assert property (take && !i_rst_pin_req && !i_rst_clk_req && i_rst_wdog_req
        |=> o_vec_addr == EVP_VEC_RST_WDOG) else $error("wdog");
    trap_vec_a: assert property (take && !i_rst_pin_req && !i_rst_clk_req
        && !i_rst_wdog_req && i_trap_req |=> o_vec_addr == {$past(base_c), EVP_OFS_TRAP}) else $error("trap");
    vec_hold_a: assert property (o_vec_valid && !i_vec_ack |=> o_vec_valid && $stable(o_vec_addr))
        else $error("hold");
    vec_drop_a: assert property (o_vec_valid && i_vec_ack |=> !o_vec_valid) else $error("drop");
    wake_mask_a: assert property (i_ccr_i_bit |=> !o_wake) else $error("masked wake");
    base_wr_a: assert property (i_base_wr |=> o_base_rdata == $past(i_base_wdata)) else $error("base");
    stop_async_a: assert property (i_stop_mode && !i_ccr_i_bit && as_ok |=> o_wake) else $error("no wake");
    stop_sync_a: assert property (i_stop_mode && !as_ok |=> !o_wake) else $error("stop wake");
    cover property (take && i_trap_req);
    cover property (o_vec_valid && !i_vec_ack ##1 o_vec_valid);
    cover property (i_stop_mode ##1 o_wake);
endmodule : evp_top_chk
bind evp_top evp_top_chk #(.N_DEV(N_DEV)) u_chk (.*);
`default_nettype wire

// [bench/evp_cpu_model.sv]
// cpu side model: requests a vector, takes it, acknowledges after 0..3 cycles
// assumes the block holds a level valid until it samples ack
`timescale 1ns/1ps
`default_nettype none
module evp_cpu_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic [1:0]  i_slow,
    input  wire logic        i_vec_valid,
    input  wire logic [15:0] i_vec_addr,
    output logic             o_req,
    output logic             o_ack,
    output logic [15:0]      o_addr,
    output logic             o_done
);
    logic [1:0] cnt;
    always_ff @(posedge i_core_clk) begin
        o_ack  <= 1'b0;
        o_done <= o_ack;
        if (i_rst) begin
            o_req <= 1'b0;
            cnt   <= 2'h0;
        end else if (i_go) begin
            o_req <= 1'b1;
            cnt   <= i_slow;
        end else if (i_vec_valid && !o_ack) begin
            // a slow cpu leaves the vector standing before it acknowledges
            o_req  <= 1'b0;
            o_addr <= i_vec_addr;
            if (cnt == 2'h0) o_ack <= 1'b1;
            else cnt <= cnt - 2'h1;
        end
    end
endmodule : evp_cpu_model
`default_nettype wire

// [bench/test_exception_vector_priority.sv]
// self-checking bench of evp_top with a cpu model on the vector side
// assumes the package defaults for the source count
`timescale 1ns/1ps
`default_nettype none
module test_exception_vector_priority
    import evp_pkg::*;
;
    logic i_core_clk, i_rst, i_ccr_i_bit, i_ccr_x_bit, i_debug_active, i_base_wr, i_stop_mode, i_wait_mode;
    logic i_rst_pin_req, i_rst_clk_req, i_rst_wdog_req, i_trap_req, i_soft_req, i_xmask_req, i_link_req, i_link_en;
    logic [7:0] i_base_wdata, o_base_rdata;
    logic [EVP_DEV_SRC_N-1:0] i_dev_req, i_dev_en, i_dev_async;
    logic [15:0] o_vec_addr, m_addr;
    logic o_vec_valid, o_wake, go, done;
    logic [1:0] slow;
    wire logic i_vec_req, i_vec_ack;
    int fail_count, cmp_count;
    evp_top u_dut (.*);
    evp_cpu_model u_cpu (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_slow(slow),
        .i_vec_valid(o_vec_valid), .i_vec_addr(o_vec_addr), .o_req(i_vec_req), .o_ack(i_vec_ack),
        .o_addr(m_addr), .o_done(done));
    always #50 i_core_clk = ~i_core_clk;
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic fetch(input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge i_core_clk) go <= 1'b1;
        @(posedge i_core_clk) go <= 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n == 40) begin
            fail_count++;
            final_report();
        end
        chk("vector", exp, m_addr);
        slow = slow + 2'h1;
    endtask : fetch
    task automatic wk(input logic [3:0] m, input logic [15:0] exp);
        @(posedge i_core_clk) {i_stop_mode, i_wait_mode, i_ccr_i_bit, i_dev_async[3]} <= m;
        @(posedge i_core_clk);
        @(negedge i_core_clk) chk("wake", exp, {15'h0, o_wake});
    endtask : wk
    // ********
    // scenarios
    // ********
    task automatic t_resets;
        @(posedge i_core_clk) {i_rst_pin_req, i_rst_clk_req, i_rst_wdog_req, i_trap_req} <= 4'hF;
        fetch(16'hFFFE);
        @(posedge i_core_clk) i_rst_pin_req <= 1'b0;
        fetch(16'hFFFC);
        @(posedge i_core_clk) i_rst_clk_req <= 1'b0;
        fetch(16'hFFFA);
        @(posedge i_core_clk) i_rst_wdog_req <= 1'b0;
        fetch(16'hFFF8);
    endtask : t_resets
    task automatic t_classes;
        @(posedge i_core_clk) {i_trap_req, i_soft_req, i_xmask_req, i_link_req, i_link_en} <= 5'h0F;
        fetch(16'hFFF6);
        @(posedge i_core_clk) i_soft_req <= 1'b0;
        fetch(16'hFFF4);
        @(posedge i_core_clk) i_ccr_x_bit <= 1'b1;
        fetch(16'hFF80);
        @(posedge i_core_clk) i_xmask_req <= 1'b0;
        fetch(16'hFFF2);
    endtask : t_classes
    task automatic t_dev;
        @(posedge i_core_clk) i_base_wr <= 1'b1;
        i_base_wdata <= 8'h12;
        i_link_req <= 1'b0;
        i_dev_req <= {1'b1, 54'h0, 1'b1};
        i_dev_en <= {1'b1, 54'h0, 1'b1};
        @(posedge i_core_clk) i_base_wr <= 1'b0;
        @(negedge i_core_clk) chk("base", 16'h0012, {8'h00, o_base_rdata});
        fetch(16'h12F0);
        @(posedge i_core_clk) i_dev_en[0] <= 1'b0;
        fetch(16'h1282);
        @(posedge i_core_clk) i_ccr_i_bit <= 1'b1;
        fetch(16'h1280);
        @(posedge i_core_clk) {i_xmask_req, i_ccr_x_bit} <= 2'b10;
        fetch(16'h12F4);
        @(posedge i_core_clk) i_ccr_i_bit <= 1'b0;
        i_xmask_req <= 1'b0;
        i_debug_active <= 1'b1;
        fetch(16'hFF82);
        @(posedge i_core_clk) i_debug_active <= 1'b0;
        i_dev_req <= 56'h8;
        i_dev_en <= 56'h8;
    endtask : t_dev
    task automatic idle_chk;
        @(negedge i_core_clk) chk("base", 16'h00FF, {8'h00, o_base_rdata});
        chk("valid", 16'h0000, {15'h0, o_vec_valid});
        chk("wake", 16'h0000, {15'h0, o_wake});
        chk("reset vector", 16'hFFFE, o_vec_addr);
    endtask : idle_chk
    task automatic t_rerst;
        @(posedge i_core_clk) i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        idle_chk();
        fetch(16'hFFEA);
    endtask : t_rerst
    initial begin
        {i_ccr_i_bit, i_ccr_x_bit, i_debug_active, i_base_wr, i_stop_mode, i_wait_mode, go, i_core_clk} = '0;
        {i_rst_pin_req, i_rst_clk_req, i_rst_wdog_req, i_trap_req, i_soft_req, i_xmask_req, i_link_req} = '0;
        {i_link_en, i_base_wdata, i_dev_req, i_dev_en, i_dev_async, slow, fail_count, cmp_count} = '0;
        i_rst = 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        idle_chk();
        t_resets();
        t_classes();
        t_dev();
        wk(4'h4, 16'h1);
        wk(4'h6, 16'h0);
        wk(4'h8, 16'h0);
        wk(4'h9, 16'h1);
        t_rerst();
        final_report();
    end
endmodule : test_exception_vector_priority
`default_nettype wire
